/* File: core/permission_check.sv */
// Permission matrix of one region: operation and level against the encoding
module permission_check (
  // Deciding region encoding
  input wire logic [prot_pkg::AP_W-1:0] ap,
  // Access attributes
  input wire logic priv,
  input wire logic is_write,
  // Verdict
  output logic allowed
);

  always_comb
  begin
    allowed = 1'b0;
    case (ap)
      prot_pkg::AP_NONE: allowed = 1'b0;
      prot_pkg::AP_PRIV_RW: allowed = priv;
      prot_pkg::AP_PRIV_RW_USER_RO: allowed = priv || !is_write;
      prot_pkg::AP_FULL: allowed = 1'b1;
      prot_pkg::AP_PRIV_RO: allowed = priv && !is_write;
      prot_pkg::AP_RO: allowed = !is_write;
      // Unused encodings behave as no access
      default: allowed = 1'b0;
    endcase
  end

endmodule : permission_check

/* File: core/prot_pkg.sv */
// Shared constants, encodings and helpers of the region protection unit
package prot_pkg;

  // ==========================================================
  // Geometry
  localparam int NUM_REGIONS = 8;
  localparam int IDX_W = 3;
  localparam int ADDR_W = 32;
  localparam int SIZE_W = 5;
  localparam int AP_W = 3;
  localparam int SEL_W = 4;

  // ==========================================================
  // Configuration selectors
  localparam logic [SEL_W-1:0] SEL_CONTROL = 4'h8;

  // ==========================================================
  // Operation codes of an access
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_EXEC = 2'h2;

  // ==========================================================
  // Permission encodings, privileged level / user level
  localparam logic [AP_W-1:0] AP_NONE = 3'h0;
  localparam logic [AP_W-1:0] AP_PRIV_RW = 3'h1;
  localparam logic [AP_W-1:0] AP_PRIV_RW_USER_RO = 3'h2;
  localparam logic [AP_W-1:0] AP_FULL = 3'h3;
  localparam logic [AP_W-1:0] AP_PRIV_RO = 3'h5;
  localparam logic [AP_W-1:0] AP_RO = 3'h6;

  // ==========================================================
  // Reset values: protection on, regions off, privileged default access open
  localparam logic RST_GLOBAL_EN = 1'b1;
  localparam logic RST_DEFAULT_PRIV = 1'b1;
  localparam logic RST_REGION_EN = 1'b0;
  localparam logic [ADDR_W-1:0] RST_BASE = 32'h0000_0000;
  localparam logic [SIZE_W-1:0] RST_SIZE = 5'h00;
  localparam logic [AP_W-1:0] RST_AP = AP_NONE;

  // ==========================================================
  // Address bits that take part in a region compare.
  // A region spans 2^(size+1) bytes; size 31 covers the whole space.
  function automatic logic [ADDR_W-1:0] region_mask(input logic [SIZE_W-1:0] size);
    logic [ADDR_W:0] span;
    span = 33'h0_0000_0001 << (6'(size) + 6'h01);
    region_mask = ~(span[ADDR_W-1:0] - 32'h0000_0001);
  endfunction : region_mask

endpackage : prot_pkg

/* File: core/region_match.sv */
// Address compare of one protection region
module region_match (
  // Region attributes
  input wire logic enable,
  input wire logic [prot_pkg::ADDR_W-1:0] base,
  input wire logic [prot_pkg::SIZE_W-1:0] size,
  // Access address and result
  input wire logic [prot_pkg::ADDR_W-1:0] addr,
  output logic hit
);

  logic [prot_pkg::ADDR_W-1:0] mask;

  assign mask = prot_pkg::region_mask(size);
  // Low base bits inside the span are ignored, so a misaligned base rounds down
  assign hit = enable && ((addr & mask) == (base & mask));

endmodule : region_match

/* File: core/region_protection_unit.sv */
// Top of the region protection unit: attributes, priority pick and verdict
module region_protection_unit (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Processor access
  input wire logic acc_valid,
  input wire logic [prot_pkg::ADDR_W-1:0] acc_addr,
  input wire logic [1:0] acc_op,
  input wire logic acc_priv,
  // Access verdict
  output logic acc_grant,
  output logic memory_manage_fault,
  output logic fault_mismatch,
  output logic [prot_pkg::ADDR_W-1:0] fault_addr,
  output logic [1:0] fault_op,
  // Attribute write
  input wire logic cfg_wr,
  input wire logic cfg_priv,
  input wire logic [prot_pkg::SEL_W-1:0] cfg_sel,
  input wire logic cfg_enable,
  input wire logic [prot_pkg::ADDR_W-1:0] cfg_base,
  input wire logic [prot_pkg::SIZE_W-1:0] cfg_size,
  input wire logic [prot_pkg::AP_W-1:0] cfg_ap,
  input wire logic cfg_default_priv,
  output logic cfg_refused,
  // Attribute readback
  input wire logic [prot_pkg::SEL_W-1:0] rd_sel,
  output logic rd_enable,
  output logic [prot_pkg::ADDR_W-1:0] rd_base,
  output logic [prot_pkg::SIZE_W-1:0] rd_size,
  output logic [prot_pkg::AP_W-1:0] rd_ap,
  output logic rd_default_priv
);

  // ==========================================================
  // Attribute storage
  logic global_en;
  logic default_priv;
  logic region_en [prot_pkg::NUM_REGIONS];
  logic [prot_pkg::ADDR_W-1:0] region_base [prot_pkg::NUM_REGIONS];
  logic [prot_pkg::SIZE_W-1:0] region_size [prot_pkg::NUM_REGIONS];
  logic [prot_pkg::AP_W-1:0] region_ap [prot_pkg::NUM_REGIONS];

  logic write_ok;
  logic sel_region;
  logic sel_control;
  logic [prot_pkg::IDX_W-1:0] wr_idx;

  assign sel_region = (cfg_sel < prot_pkg::SEL_CONTROL);
  assign sel_control = (cfg_sel == prot_pkg::SEL_CONTROL);
  assign wr_idx = cfg_sel[prot_pkg::IDX_W-1:0];
  // User level writes are dropped whole, never partially applied
  assign write_ok = cfg_wr && cfg_priv;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      global_en <= prot_pkg::RST_GLOBAL_EN;
      default_priv <= prot_pkg::RST_DEFAULT_PRIV;
    end
    else if (write_ok && sel_control)
    begin
      global_en <= cfg_enable;
      default_priv <= cfg_default_priv;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < prot_pkg::NUM_REGIONS; i++)
      begin
        region_en[i] <= prot_pkg::RST_REGION_EN;
        region_base[i] <= prot_pkg::RST_BASE;
        region_size[i] <= prot_pkg::RST_SIZE;
        region_ap[i] <= prot_pkg::RST_AP;
      end
    end
    else if (write_ok && sel_region)
    begin
      region_en[wr_idx] <= cfg_enable;
      region_base[wr_idx] <= cfg_base;
      region_size[wr_idx] <= cfg_size;
      region_ap[wr_idx] <= cfg_ap;
    end
  end

  // Unmapped selector or user level attempt is reported for one cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cfg_refused <= 1'b0;
    end
    else
    begin
      cfg_refused <= cfg_wr && !(cfg_priv && (sel_region || sel_control));
    end
  end

  // ==========================================================
  // Readback, one cycle behind rd_sel
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rd_enable <= 1'b0;
      rd_base <= 32'h0000_0000;
      rd_size <= 5'h00;
      rd_ap <= 3'h0;
      rd_default_priv <= 1'b0;
    end
    else
    begin
      rd_default_priv <= default_priv;
      if (rd_sel < prot_pkg::SEL_CONTROL)
      begin
        rd_enable <= region_en[rd_sel[prot_pkg::IDX_W-1:0]];
        rd_base <= region_base[rd_sel[prot_pkg::IDX_W-1:0]];
        rd_size <= region_size[rd_sel[prot_pkg::IDX_W-1:0]];
        rd_ap <= region_ap[rd_sel[prot_pkg::IDX_W-1:0]];
      end
      else if (rd_sel == prot_pkg::SEL_CONTROL)
      begin
        rd_enable <= global_en;
        rd_base <= 32'h0000_0000;
        rd_size <= 5'h00;
        rd_ap <= 3'h0;
      end
      else
      begin
        rd_enable <= 1'b0;
        rd_base <= 32'h0000_0000;
        rd_size <= 5'h00;
        rd_ap <= 3'h0;
      end
    end
  end

  // ==========================================================
  // Region compare and priority pick
  logic [prot_pkg::NUM_REGIONS-1:0] match_vec;
  logic hit;
  logic [prot_pkg::IDX_W-1:0] win_idx;

  for (genvar g = 0; g < prot_pkg::NUM_REGIONS; g++)
  begin : g_region
    region_match u_match (
      .enable(region_en[g]),
      .base(region_base[g]),
      .size(region_size[g]),
      .addr(acc_addr),
      .hit(match_vec[g])
    );
  end

  // Ascending scan: the last hit found is the highest index
  always_comb
  begin
    hit = 1'b0;
    win_idx = 3'h0;
    for (int i = 0; i < prot_pkg::NUM_REGIONS; i++)
    begin
      if (match_vec[i])
      begin
        hit = 1'b1;
        win_idx = i[prot_pkg::IDX_W-1:0];
      end
    end
  end

  // ==========================================================
  // Permission verdict
  logic is_write;
  logic region_ok;
  logic default_ok;
  logic next_allowed;
  logic [prot_pkg::AP_W-1:0] win_ap;

  // Execute is judged as a read of the instruction word
  assign is_write = (acc_op == prot_pkg::OP_WRITE);
  assign win_ap = region_ap[win_idx];

  permission_check u_perm (
    .ap(win_ap),
    .priv(acc_priv),
    .is_write(is_write),
    .allowed(region_ok)
  );

  assign default_ok = acc_priv && default_priv;

  always_comb
  begin
    if (!global_en)
    begin
      next_allowed = 1'b1;
    end
    else if (hit)
    begin
      next_allowed = region_ok;
    end
    else
    begin
      next_allowed = default_ok;
    end
  end

  // ==========================================================
  // Verdict registers; the core commits only on acc_grant
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      acc_grant <= 1'b0;
      memory_manage_fault <= 1'b0;
    end
    else
    begin
      acc_grant <= acc_valid && next_allowed;
      memory_manage_fault <= acc_valid && !next_allowed;
    end
  end

  // Fault details hold until the next fault
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fault_mismatch <= 1'b0;
      fault_addr <= 32'h0000_0000;
      fault_op <= 2'h0;
    end
    else if (acc_valid && !next_allowed)
    begin
      fault_mismatch <= !hit;
      fault_addr <= acc_addr;
      fault_op <= acc_op;
    end
  end

  // ==========================================================
  // Checks
  a_verdict_once: assert property (@(posedge mclk) disable iff (rst)
    acc_valid |=> (acc_grant != memory_manage_fault))
    else $error("Access got no verdict or two");

  a_quiet_idle: assert property (@(posedge mclk) disable iff (rst)
    !acc_valid |=> !acc_grant && !memory_manage_fault)
    else $error("Verdict without access");

  a_disabled_no_fault: assert property (@(posedge mclk) disable iff (rst)
    acc_valid && !global_en |=> acc_grant && !memory_manage_fault)
    else $error("Fault while protection disabled");

  a_highest_region: assert property (@(posedge mclk) disable iff (rst)
    hit |-> match_vec[win_idx] && ((match_vec >> win_idx) == 8'h01))
    else $error("Lower region chosen over higher match");

  a_none_faults: assert property (@(posedge mclk) disable iff (rst)
    acc_valid && global_en && hit && win_ap == prot_pkg::AP_NONE
    |=> memory_manage_fault && !fault_mismatch)
    else $error("No-access region let access pass");

  a_readonly_write: assert property (@(posedge mclk) disable iff (rst)
    acc_valid && global_en && hit && win_ap == prot_pkg::AP_RO && acc_op == prot_pkg::OP_WRITE
    |=> memory_manage_fault && fault_op == prot_pkg::OP_WRITE)
    else $error("Write to read-only region passed");

  a_user_ro_read: assert property (@(posedge mclk) disable iff (rst)
    acc_valid && global_en && hit && win_ap == prot_pkg::AP_PRIV_RW_USER_RO && !is_write
    |=> acc_grant)
    else $error("User read of user read-only region refused");

  a_default_user: assert property (@(posedge mclk) disable iff (rst)
    acc_valid && global_en && !hit && !acc_priv
    |=> memory_manage_fault && fault_mismatch)
    else $error("User access outside regions not faulted");

  a_default_priv: assert property (@(posedge mclk) disable iff (rst)
    acc_valid && global_en && !hit && acc_priv
    |=> acc_grant == $past(default_priv))
    else $error("Default region bit not honoured");

  a_user_cfg_dropped: assert property (@(posedge mclk) disable iff (rst)
    cfg_wr && !cfg_priv
    |=> $stable(global_en) && $stable(default_priv) && $stable(region_ap[0]) && cfg_refused)
    else $error("User level altered attributes");

  a_priv_cfg_applied: assert property (@(posedge mclk) disable iff (rst)
    cfg_wr && cfg_priv && cfg_sel == prot_pkg::SEL_CONTROL && rd_sel == prot_pkg::SEL_CONTROL
    ##1 rd_sel == prot_pkg::SEL_CONTROL |=> rd_enable == $past(cfg_enable, 2))
    else $error("Privileged write not visible on readback");

  a_fault_kept: assert property (@(posedge mclk) disable iff (rst)
    !(acc_valid && !next_allowed)
    |=> $stable(fault_mismatch) && $stable(fault_addr) && $stable(fault_op))
    else $error("Fault details changed without a fault");

  a_fault_addr: assert property (@(posedge mclk) disable iff (rst)
    acc_valid && !next_allowed |=> fault_addr == $past(acc_addr) && fault_op == $past(acc_op))
    else $error("Fault details do not name the denied access");

  a_priv_only: assert property (@(posedge mclk) disable iff (rst)
    acc_valid && global_en && hit && win_ap == prot_pkg::AP_PRIV_RW && !acc_priv
    |=> memory_manage_fault && !fault_mismatch)
    else $error("User access to privileged region passed");

  a_full_access: assert property (@(posedge mclk) disable iff (rst)
    acc_valid && global_en && hit && win_ap == prot_pkg::AP_FULL
    |=> acc_grant)
    else $error("Full access region refused an access");

  a_user_ro_write: assert property (@(posedge mclk) disable iff (rst)
    acc_valid && global_en && hit && win_ap == prot_pkg::AP_PRIV_RW_USER_RO && !acc_priv && is_write
    |=> memory_manage_fault)
    else $error("User write to user read-only region passed");

  a_priv_ro: assert property (@(posedge mclk) disable iff (rst)
    acc_valid && global_en && hit && win_ap == prot_pkg::AP_PRIV_RO && (is_write || !acc_priv)
    |=> memory_manage_fault)
    else $error("Privileged read-only region let a write or user access pass");

endmodule : region_protection_unit

/* File: tb/cpu_core_model.sv */
// Processor-side model that issues privileged and unprivileged accesses
module cpu_core_model (
  // Clock
  input wire logic mclk,
  // Access request
  output logic acc_valid,
  output logic [prot_pkg::ADDR_W-1:0] acc_addr,
  output logic [1:0] acc_op,
  output logic acc_priv,
  // Verdict
  input wire logic acc_grant,
  input wire logic memory_manage_fault
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    acc_valid = 1'b0;
    acc_addr = 32'h0000_0000;
    acc_op = 2'h0;
    acc_priv = 1'b0;
  end

  // ==========================================================
  // One access; the verdict is sampled just after the edge that takes it
  task automatic access(input logic [31:0] addr, input logic [1:0] op, input logic priv,
                        output logic [1:0] verdict);
    @(posedge mclk);
    #1;
    acc_valid = 1'b1;
    acc_addr = addr;
    acc_op = op;
    acc_priv = priv;
    @(posedge mclk);
    #1;
    verdict = {acc_grant, memory_manage_fault};
    acc_valid = 1'b0;
    // Unqualified lines do not keep the last value
    acc_addr = ~addr;
    acc_op = ~op;
    acc_priv = ~priv;
  endtask : access
endmodule : cpu_core_model

/* File: tb/test_region_protection_unit.sv */
// Self-checking bench of the region protection unit
`define CHECK(name, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", name, exp, got); \
    end \
  end

module test_region_protection_unit;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic acc_valid, acc_priv, acc_grant, memory_manage_fault, fault_mismatch;
  logic [31:0] acc_addr, fault_addr;
  logic [1:0] acc_op, fault_op;
  logic cfg_wr = 1'b0;
  logic cfg_priv = 1'b0;
  logic [3:0] cfg_sel = 4'h0;
  logic cfg_enable = 1'b0;
  logic [31:0] cfg_base = 32'h0000_0000;
  logic [4:0] cfg_size = 5'h00;
  logic [2:0] cfg_ap = 3'h0;
  logic cfg_default_priv = 1'b0;
  logic cfg_refused;
  logic [3:0] rd_sel = 4'h0;
  logic rd_enable, rd_default_priv;
  logic [31:0] rd_base;
  logic [4:0] rd_size;
  logic [2:0] rd_ap;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [40:0] rb;
  logic [2:0] aps [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};

  always #20 mclk = ~mclk;

  region_protection_unit dut_u (.mclk(mclk), .rst(rst), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .acc_op(acc_op), .acc_priv(acc_priv), .acc_grant(acc_grant), .memory_manage_fault(memory_manage_fault),
    .fault_mismatch(fault_mismatch), .fault_addr(fault_addr), .fault_op(fault_op), .cfg_wr(cfg_wr),
    .cfg_priv(cfg_priv), .cfg_sel(cfg_sel), .cfg_enable(cfg_enable), .cfg_base(cfg_base),
    .cfg_size(cfg_size), .cfg_ap(cfg_ap), .cfg_default_priv(cfg_default_priv), .cfg_refused(cfg_refused),
    .rd_sel(rd_sel), .rd_enable(rd_enable), .rd_base(rd_base), .rd_size(rd_size), .rd_ap(rd_ap),
    .rd_default_priv(rd_default_priv));

  cpu_core_model cpu_u (.mclk(mclk), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_op(acc_op),
    .acc_priv(acc_priv), .acc_grant(acc_grant), .memory_manage_fault(memory_manage_fault));

  // ==========================================================
  // Expected permission of one encoding
  function automatic logic allow(input logic [2:0] ap, input logic priv, input logic wr);
    case (ap)
      prot_pkg::AP_PRIV_RW: allow = priv;
      prot_pkg::AP_PRIV_RW_USER_RO: allow = priv | ~wr;
      prot_pkg::AP_FULL: allow = 1'b1;
      prot_pkg::AP_PRIV_RO: allow = priv & ~wr;
      prot_pkg::AP_RO: allow = ~wr;
      default: allow = 1'b0;
    endcase
  endfunction : allow

  // ==========================================================
  // Access protocol tasks
  task automatic chk_acc(input logic [31:0] addr, input logic [1:0] op, input logic priv, input logic ok);
    logic [1:0] v;
    cpu_u.access(addr, op, priv, v);
    `CHECK("verdict", {ok, ~ok}, v)
  endtask : chk_acc

  task automatic cfg_write(input logic [3:0] sel, input logic en, input logic [31:0] base,
                           input logic [4:0] size, input logic [2:0] ap, input logic dp, input logic priv);
    @(posedge mclk);
    #1;
    cfg_wr = 1'b1;
    cfg_sel = sel;
    cfg_enable = en;
    cfg_base = base;
    cfg_size = size;
    cfg_ap = ap;
    cfg_default_priv = dp;
    cfg_priv = priv;
    @(posedge mclk);
    #1;
    cfg_wr = 1'b0;
    `CHECK("cfg_refused", ~priv | (sel > 4'h8), cfg_refused)
  endtask : cfg_write

  task automatic read_back(input logic [3:0] sel);
    @(posedge mclk);
    #1;
    rd_sel = sel;
    @(posedge mclk);
    #1;
    rb = {rd_enable, rd_base, rd_size, rd_ap};
  endtask : read_back

  task automatic end_of_test;
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    read_back(4'h8);
    `CHECK("ctrl_rb", {1'b1, 40'h00_0000_0000}, rb)
    `CHECK("default_rb", 1'b1, rd_default_priv)
    read_back(4'h0);
    `CHECK("region0_rb", 41'h000_0000_0000, rb)
    chk_acc(32'h0000_0100, prot_pkg::OP_READ, 1'b0, 1'b0);
    `CHECK("mismatch", 1'b1, fault_mismatch)
    chk_acc(32'h0000_0100, prot_pkg::OP_EXEC, 1'b1, 1'b1);
    // Every encoding, unused ones included, against every level and operation
    for (int i = 0; i < 8; i++)
    begin
      cfg_write(4'h2, 1'b1, 32'h1000_0000, 5'h0b, aps[i], 1'b1, 1'b1);
      read_back(4'h2);
      `CHECK("region2_rb", {1'b1, 32'h1000_0000, 5'h0b, aps[i]}, rb)
      for (int p = 0; p < 2; p++)
        for (int o = 0; o < 3; o++)
          chk_acc(32'h1000_0ffc, 2'(o), 1'(p), allow(aps[i], 1'(p), o == 1));
    end
    cfg_write(4'h2, 1'b1, 32'h1000_0000, 5'h0b, prot_pkg::AP_RO, 1'b1, 1'b1);
    chk_acc(32'h1000_0004, prot_pkg::OP_WRITE, 1'b0, 1'b0);
    `CHECK("fault_info", {1'b0, 32'h1000_0004, prot_pkg::OP_WRITE},
      {fault_mismatch, fault_addr, fault_op})
    chk_acc(32'h1000_1000, prot_pkg::OP_READ, 1'b0, 1'b0);
    // Region 5 covers everything with no access, region 7 opens a window
    cfg_write(4'h5, 1'b1, 32'h1000_0000, 5'h1f, prot_pkg::AP_NONE, 1'b1, 1'b1);
    chk_acc(32'h1000_0000, prot_pkg::OP_READ, 1'b1, 1'b0);
    chk_acc(32'h2000_0000, prot_pkg::OP_READ, 1'b1, 1'b0);
    cfg_write(4'h7, 1'b1, 32'h1000_0800, 5'h0a, prot_pkg::AP_FULL, 1'b1, 1'b1);
    chk_acc(32'h1000_0900, prot_pkg::OP_WRITE, 1'b0, 1'b1);
    chk_acc(32'h1000_0700, prot_pkg::OP_WRITE, 1'b1, 1'b0);
    cfg_write(4'h5, 1'b0, 32'h1000_0000, 5'h1f, prot_pkg::AP_NONE, 1'b1, 1'b1);
    chk_acc(32'h1000_0000, prot_pkg::OP_READ, 1'b1, 1'b1);
    chk_acc(32'h1000_0000, prot_pkg::OP_WRITE, 1'b1, 1'b0);
    // Default region closed to every level
    cfg_write(4'h8, 1'b1, 32'h0000_0000, 5'h00, 3'h0, 1'b0, 1'b1);
    chk_acc(32'h3000_0000, prot_pkg::OP_READ, 1'b1, 1'b0);
    `CHECK("mismatch", 1'b1, fault_mismatch)
    `CHECK("default_rb", 1'b0, rd_default_priv)
    cfg_write(4'h8, 1'b1, 32'h0000_0000, 5'h00, 3'h0, 1'b1, 1'b0);
    cfg_write(4'h9, 1'b1, 32'h0000_0000, 5'h00, 3'h0, 1'b1, 1'b1);
    cfg_write(4'h7, 1'b0, 32'h0000_0000, 5'h00, 3'h0, 1'b1, 1'b0);
    `CHECK("default_rb", 1'b0, rd_default_priv)
    read_back(4'h7);
    `CHECK("region7_rb", {1'b1, 32'h1000_0800, 5'h0a, prot_pkg::AP_FULL}, rb)
    // Control read back after the refused writes, so global enable still shows set
    read_back(4'h8);
    `CHECK("ctrl_rb", {1'b1, 40'h00_0000_0000}, rb)
    // Global disable lets everything through
    cfg_write(4'h8, 1'b0, 32'h0000_0000, 5'h00, 3'h0, 1'b0, 1'b1);
    chk_acc(32'h3000_0000, prot_pkg::OP_WRITE, 1'b0, 1'b1);
    chk_acc(32'h1000_0000, prot_pkg::OP_WRITE, 1'b0, 1'b1);
    read_back(4'h8);
    `CHECK("ctrl_rb", 41'h000_0000_0000, rb)
    // Reset in mid-run must bring back the reset attributes, regions off and protection on
    rst = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    read_back(4'h7);
    `CHECK("region7_rb", 41'h000_0000_0000, rb)
    read_back(4'h8);
    `CHECK("ctrl_rb", {1'b1, 40'h00_0000_0000}, rb)
    chk_acc(32'h1000_0900, prot_pkg::OP_WRITE, 1'b0, 1'b0);
    chk_acc(32'h1000_0900, prot_pkg::OP_WRITE, 1'b1, 1'b1);
    end_of_test();
  end
endmodule : test_region_protection_unit
